// *** iexu_pkg.sv ***
// iexu_pkg: shared types and constants of the instruction execute unit
// assumes a single 40 MHz core clock and byte-wide data memory
package iexu_pkg;

   // ==========================================================
   // widths
   localparam int DW  = 8;                   // data byte width
   localparam int DAW = 12;                  // data memory address width
   localparam int PAW = 16;                  // program memory address width
   localparam int PWW = 16;                  // program word width

   // ==========================================================
   // register map over the plain register port
   localparam logic [2:0] REG_WORK   = 3'h0;   // working register
   localparam logic [2:0] REG_FLAGS  = 3'h1;   // status flags
   localparam logic [2:0] REG_PTRLO  = 3'h2;   // table pointer low byte
   localparam logic [2:0] REG_PTRHI  = 3'h3;   // table pointer high byte
   localparam logic [2:0] REG_TBLHI  = 3'h4;   // table read high byte
   localparam logic [2:0] REG_SECT   = 3'h5;   // section of basic instructions
   localparam logic [7:0] RST_BYTE   = 8'h00;  // reset value of every register
   localparam logic [7:0] LAST_PAGE  = 8'hff;  // page of last-page table reads
   localparam logic [3:0] BCD_MAX    = 4'h9;   // largest decimal nibble
   localparam logic [3:0] BCD_FIX    = 4'h6;   // decimal nibble correction

   // ==========================================================
   // flag field positions in the flag register
   localparam int F_CARRY = 0;
   localparam int F_HALF  = 1;
   localparam int F_ZERO  = 2;
   localparam int F_RANGE = 3;
   localparam int F_SIGN  = 4;

   typedef struct packed {
      logic signedCarry;                     // sign of the true signed sum
      logic signedRange;                     // signed overflow
      logic zero;                            // result was zero
      logic halfCarry;                       // carry out of low nibble
      logic carry;                           // carry out of bit 7
   } iexu_flags_t;

   // ==========================================================
   // instruction set handled by this unit
   typedef enum logic [4:0] {
      OP_SWAP_W   = 5'h00, OP_SKIP_Z   = 5'h01, OP_SKIP_ZLD = 5'h02,
      OP_SKIP_BIT = 5'h03, OP_TRD_PG   = 5'h04, OP_TRD_LAST = 5'h05,
      OP_ITRD_PG  = 5'h06, OP_ITRD_LST = 5'h07, OP_XOR_W    = 5'h08,
      OP_XOR_MEM  = 5'h09, OP_XOR_IMM  = 5'h0a, OP_XADC     = 5'h0b,
      OP_XADC_M   = 5'h0c, OP_XADD     = 5'h0d, OP_XADD_M   = 5'h0e,
      OP_XAND     = 5'h0f, OP_XAND_M   = 5'h10, OP_XCLR     = 5'h11,
      OP_XCLR_BIT = 5'h12, OP_XCPL     = 5'h13, OP_XCPL_W   = 5'h14,
      OP_XDAA     = 5'h15, OP_XDEC     = 5'h16, OP_XDEC_W   = 5'h17,
      OP_XINC     = 5'h18, OP_XINC_W   = 5'h19, OP_XMOV_W   = 5'h1a,
      OP_XMOV_M   = 5'h1b
   } iexu_op_t;

   typedef struct packed {
      iexu_op_t       op;                    // operation
      logic [DAW-1:0] addr;                  // data memory address
      logic [2:0]     bitSel;                // bit index i
      logic [DW-1:0]  imm;                   // immediate data
   } iexu_req_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0, ST_RDMEM = 3'h1, ST_EXEC = 3'h2, ST_TBLRD = 3'h3,
      ST_TBLWR = 3'h4, ST_WRMEM = 3'h5, ST_DUMMY = 3'h6
   } iexu_state_t;

endpackage

// *** iexu_core.sv ***
// iexu_core: executes one instruction at a time against data and program memory
// assumes memories answer a read strobe with data in the next cycle
// Operation
// - swap memory nibbles into working register
// - skip next instruction when memory byte zero
// - load working register, skip when zero
// - skip when selected memory bit zero
// - a skip adds one dummy cycle
// - page read uses high and low pointer
// - last page read uses low pointer only
// - increment low pointer, then page read
// - increment low pointer, then last-page read
// - exclusive-or, only zero flag changes
// - extended forms reach every memory section
// - add with carry updates five flags
// - add without carry updates five flags
// - and operation, only zero flag changes
// - clear byte or one bit, no flags
// - complement in place or to working
// - decimal adjust nibbles, result to memory
// - decimal adjust changes only carry
// - decrement in place or to working
// - increment in place or to working
// - move either way, no flags
`timescale 1ns/1ps
module iexu_core
   import iexu_pkg::*;
(
   input  wire logic            core_clk,    // core clock, 40 MHz
   input  wire logic            resetn,      // asynchronous reset, active low
   input  wire logic            opValid,     // instruction offered
   input  wire iexu_req_t       opReq,       // instruction and operands
   output logic                 opReady,     // unit idle, takes opReq
   output logic                 opDone,      // instruction finished
   output logic                 instSkip,    // dummy cycle of a taken skip
   output logic [DAW-1:0]       dmAddr,      // data memory address
   output logic                 dmRe,        // data memory read strobe
   output logic                 dmWe,        // data memory write strobe
   output logic [DW-1:0]        dmWdata,     // data memory write data
   input  wire logic [DW-1:0]   dmRdata,     // data memory read data
   output logic [PAW-1:0]       pmAddr,      // program memory address
   output logic                 pmRe,        // program memory read strobe
   input  wire logic [PWW-1:0]  pmRdata,     // program word
   input  wire logic [2:0]      regAddr,     // register port address
   input  wire logic [DW-1:0]   regWdata,    // register port write data
   input  wire logic            regWr,       // register write strobe
   input  wire logic            regRd,       // register read strobe
   output logic [DW-1:0]        regRdata     // register read data, next cycle
);

   // ==========================================================
   // decode helpers
   // true for the four table reads
   function automatic logic isTable(iexu_op_t op);
      return op inside {OP_TRD_PG, OP_TRD_LAST, OP_ITRD_PG, OP_ITRD_LST};
   endfunction

   // true for forms that write the alu result to data memory
   function automatic logic toMem(iexu_op_t op);
      return op inside {OP_XOR_MEM, OP_XADC_M, OP_XADD_M, OP_XAND_M, OP_XCLR,
                        OP_XCLR_BIT, OP_XCPL, OP_XDAA, OP_XDEC, OP_XINC, OP_XMOV_M};
   endfunction

   // true for the extended instructions
   function automatic logic isExt(iexu_op_t op);
      return op >= OP_XADC;
   endfunction

   // ==========================================================
   // state
   iexu_state_t     state_q, state_d;        // sequencer
   iexu_req_t       req_q;                   // latched instruction
   iexu_flags_t     flags_q, flags_d;        // status flags
   logic [DW-1:0]   work_q, work_d;          // working register
   logic [DW-1:0]   ptrLo_q;                 // table pointer low byte
   logic [DW-1:0]   ptrHi_q;                 // table pointer high byte
   logic [DW-1:0]   tblHi_q;                 // table read high byte
   logic [DW-1:0]   sect_q;                  // section for basic instructions
   logic [DAW-1:0]  dmAddr_q;                // registered memory address
   logic [DW-1:0]   dmWdata_q, res;          // write data, alu result
   logic [PAW-1:0]  pmAddr_q;                // registered program address
   logic [DW-1:0]   regRdata_q;              // register read data
   logic            skip, wrW, wrM;          // alu decisions

   // ==========================================================
   // handshake and strobes
   wire take      = opValid && (state_q == ST_IDLE);
   wire incrPtr   = take && (opReq.op inside {OP_ITRD_PG, OP_ITRD_LST});
   wire [DW-1:0] ptrLoNext = incrPtr ? DW'(ptrLo_q + 8'h01) : ptrLo_q;
   wire lastPage  = opReq.op inside {OP_TRD_LAST, OP_ITRD_LST};
   wire [DAW-1:0] basicAddr = DAW'({sect_q[3:0], opReq.addr[7:0]});
   wire execBusy  = state_q == ST_EXEC;

   assign opReady  = state_q == ST_IDLE;
   assign dmRe     = state_q == ST_RDMEM;
   assign dmWe     = state_q == ST_WRMEM;
   assign pmRe     = state_q == ST_TBLRD;
   assign instSkip = state_q == ST_DUMMY;
   assign opDone   = dmWe || instSkip || (execBusy && !wrM && !skip);
   assign dmAddr   = dmAddr_q;
   assign dmWdata  = dmWdata_q;
   assign pmAddr   = pmAddr_q;
   assign regRdata = regRdata_q;

   // ==========================================================
   // alu: result, flags and skip for the instruction in ST_EXEC
   wire [DW-1:0] m   = dmRdata;
   wire [DW-1:0] w   = work_q;
   wire          cin = (req_q.op inside {OP_XADC, OP_XADC_M}) && flags_q.carry;
   wire [8:0]    sum = 9'(w) + 9'(m) + 9'(cin);
   wire [4:0]    lowSum = 5'(w[3:0]) + 5'(m[3:0]) + 5'(cin);
   wire          lowFix = (w[3:0] > BCD_MAX) || flags_q.halfCarry;
   wire          highFix = (w[7:4] > BCD_MAX) || flags_q.carry;
   wire [8:0]    daaSum = 9'(w) + 9'({highFix ? BCD_FIX : 4'h0, lowFix ? BCD_FIX : 4'h0});
   wire [DW-1:0] bitMask = DW'(8'h01 << req_q.bitSel);

   // operation decode and result select
   always_comb begin
      res     = m;
      skip    = 1'b0;
      flags_d = flags_q;
      wrW     = 1'b0;
      unique case (req_q.op)
         OP_SWAP_W: begin
            res = {m[3:0], m[7:4]};
            wrW = 1'b1;
         end
         OP_SKIP_Z: skip = (m == 8'h00);
         OP_SKIP_ZLD: begin
            wrW  = 1'b1;
            skip = (m == 8'h00);
         end
         OP_SKIP_BIT: skip = !m[req_q.bitSel];
         OP_XOR_W, OP_XOR_MEM: res = w ^ m;
         OP_XOR_IMM: res = w ^ req_q.imm;
         OP_XADC, OP_XADC_M, OP_XADD, OP_XADD_M: begin
            res = sum[7:0];
            flags_d.carry       = sum[8];
            flags_d.halfCarry   = lowSum[4];
            flags_d.signedRange = (w[7] == m[7]) && (sum[7] != w[7]);
            flags_d.signedCarry = sum[7] ^ flags_d.signedRange;
         end
         OP_XAND, OP_XAND_M: res = w & m;
         OP_XCLR: res = 8'h00;
         OP_XCLR_BIT: res = m & ~bitMask;
         OP_XCPL, OP_XCPL_W: res = ~m;
         OP_XDAA: begin
            res = daaSum[7:0];
            flags_d.carry = flags_q.carry || highFix || daaSum[8];
         end
         OP_XDEC, OP_XDEC_W: res = DW'(m - 8'h01);
         OP_XINC, OP_XINC_W: res = DW'(m + 8'h01);
         OP_XMOV_W: res = m;
         OP_XMOV_M: res = w;
         default: res = m;                                            // only table reads reach here, and they never enter ST_EXEC
      endcase
      if (req_q.op inside {OP_SWAP_W, OP_XOR_W, OP_XOR_IMM, OP_XADC, OP_XADD, OP_XAND,
                           OP_XCPL_W, OP_XDEC_W, OP_XINC_W, OP_XMOV_W})
         wrW = 1'b1;
      // zero flag on every instruction that reports it
      if (req_q.op inside {OP_XOR_W, OP_XOR_MEM, OP_XOR_IMM, OP_XADC, OP_XADC_M, OP_XADD,
                           OP_XADD_M, OP_XAND, OP_XAND_M, OP_XCPL, OP_XCPL_W, OP_XDEC,
                           OP_XDEC_W, OP_XINC, OP_XINC_W})
         flags_d.zero = (res == 8'h00);
   end
   assign wrM = toMem(req_q.op);

   // ==========================================================
   // sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:  if (opValid) state_d = isTable(opReq.op) ? ST_TBLRD : ST_RDMEM;
         ST_RDMEM: state_d = ST_EXEC;
         ST_EXEC:  state_d = wrM ? ST_WRMEM : (skip ? ST_DUMMY : ST_IDLE);
         ST_TBLRD: state_d = ST_TBLWR;
         ST_TBLWR: state_d = ST_WRMEM;
         ST_WRMEM: state_d = ST_IDLE;
         ST_DUMMY: state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   // working register: alu write wins over a port write
   always_comb begin
      work_d = work_q;
      if (regWr && regAddr == REG_WORK) work_d = regWdata;
      if (execBusy && wrW) work_d = res;
   end

   // ==========================================================
   // sequencer and instruction latch
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         req_q   <= '0;
      end else begin
         state_q <= state_d;
         if (take) req_q <= opReq;
      end
   end

   // memory address and write data registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dmAddr_q  <= '0;
         dmWdata_q <= RST_BYTE;
         pmAddr_q  <= '0;
      end else begin
         if (take) dmAddr_q <= isExt(opReq.op) ? opReq.addr : basicAddr;
         if (take && isTable(opReq.op))
            pmAddr_q <= {lastPage ? LAST_PAGE : ptrHi_q, ptrLoNext};
         if (execBusy) dmWdata_q <= res;
         if (state_q == ST_TBLWR) dmWdata_q <= pmRdata[7:0];
      end
   end

   // working register and flags
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         work_q  <= RST_BYTE;
         flags_q <= '0;
      end else begin
         work_q <= work_d;
         if (execBusy) flags_q <= flags_d;
         else if (regWr && regAddr == REG_FLAGS) flags_q <= regWdata[4:0];
      end
   end

   // table pointers, table high byte and section
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ptrLo_q <= RST_BYTE;
         ptrHi_q <= RST_BYTE;
         tblHi_q <= RST_BYTE;
         sect_q  <= RST_BYTE;
      end else begin
         if (incrPtr) ptrLo_q <= ptrLoNext;
         else if (regWr && regAddr == REG_PTRLO) ptrLo_q <= regWdata;
         if (regWr && regAddr == REG_PTRHI) ptrHi_q <= regWdata;
         if (state_q == ST_TBLWR) tblHi_q <= pmRdata[15:8];
         else if (regWr && regAddr == REG_TBLHI) tblHi_q <= regWdata;
         if (regWr && regAddr == REG_SECT) sect_q <= regWdata;
      end
   end

   // ==========================================================
   // register read port
   wire [DW-1:0] readMux =
      (regAddr == REG_WORK)  ? work_q :
      (regAddr == REG_FLAGS) ? DW'(flags_q) :
      (regAddr == REG_PTRLO) ? ptrLo_q :
      (regAddr == REG_PTRHI) ? ptrHi_q :
      (regAddr == REG_TBLHI) ? tblHi_q :
      (regAddr == REG_SECT)  ? sect_q : 8'h00;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) regRdata_q <= RST_BYTE;
      else regRdata_q <= regRd ? readMux : 8'h00;
   end

   // ==========================================================
   // checks
   swap_result_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_SWAP_W |=> work_q == {$past(dmRdata[3:0]), $past(dmRdata[7:4])}
         && flags_q == $past(flags_q))
      else $error("nibble swap result wrong");

   skip_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_SKIP_Z |=> instSkip == ($past(dmRdata) == 8'h00))
      else $error("zero skip decision wrong");

   skip_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_SKIP_ZLD |=> work_q == $past(dmRdata))
      else $error("skip load value wrong");

   bit_skip_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_SKIP_BIT && !dmRdata[req_q.bitSel] |=> instSkip && opDone ##1 opReady)
      else $error("bit skip not taken");

   skip_length_a: assert property (@(posedge core_clk) disable iff (!resetn)
      instSkip |-> $past(state_q) == ST_EXEC && $past(state_q, 2) == ST_RDMEM)
      else $error("skip cycle out of place");

   ptr_incr_a: assert property (@(posedge core_clk) disable iff (!resetn)
      incrPtr |=> ptrLo_q == DW'($past(ptrLo_q) + 8'h01) && pmRe && pmAddr[7:0] == ptrLo_q)
      else $error("table pointer not incremented first");

   last_page_a: assert property (@(posedge core_clk) disable iff (!resetn)
      take && lastPage |=> pmAddr[15:8] == LAST_PAGE)
      else $error("last page address wrong");

   xor_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_XOR_W |=> flags_q.zero == (work_q == 8'h00)
         && flags_q.carry == $past(flags_q.carry))
      else $error("xor flag update wrong");

   clear_byte_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_XCLR |=> dmWe && dmWdata == 8'h00 && flags_q == $past(flags_q))
      else $error("clear did not write zero");

   ext_addr_a: assert property (@(posedge core_clk) disable iff (!resetn)
      dmRe && isExt(req_q.op) |-> dmAddr == req_q.addr)
      else $error("extended address not direct");

   move_flags_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op inside {OP_XMOV_W, OP_XMOV_M} |=> flags_q == $past(flags_q))
      else $error("move changed a flag");

   adc_sum_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_XADC |=> work_q == DW'($past(work_q) + $past(dmRdata) + DW'($past(flags_q.carry))))
      else $error("add with carry result wrong");

   daa_flags_a: assert property (@(posedge core_clk) disable iff (!resetn)
      execBusy && req_q.op == OP_XDAA |=> dmWe && flags_q.zero == $past(flags_q.zero)
         && flags_q.halfCarry == $past(flags_q.halfCarry) && flags_q.signedRange == $past(flags_q.signedRange))
      else $error("decimal adjust changed a flag other than carry");

endmodule

// *** iexu_mem_model.sv ***
// iexu_mem_model: data memory and program memory standing beside the execute unit
// assumes read strobes are answered with data in the next cycle only
`timescale 1ns/1ps
module iexu_mem_model
   import iexu_pkg::*;
(
   input  wire logic            core_clk,  // core clock
   input  wire logic [DAW-1:0]  dmAddr,    // data memory address
   input  wire logic            dmRe,      // data read strobe
   input  wire logic            dmWe,      // data write strobe
   input  wire logic [DW-1:0]   dmWdata,   // data write value
   output logic [DW-1:0]        dmRdata,   // data read value
   input  wire logic [PAW-1:0]  pmAddr,    // program word address
   input  wire logic            pmRe,      // program read strobe
   output logic [PWW-1:0]       pmRdata    // program word
);
   // ==========================================================
   // storage and answer registers
   logic [DW-1:0]  dmemArr [0:(1<<DAW)-1];  // byte-wide data store
   logic [DW-1:0]  rdQ      = 8'h00;        // last data answer
   logic [PWW-1:0] pwQ      = 16'h0000;     // last program answer
   logic           rdValidQ = 1'b0;         // data answer stands this cycle
   logic           pwValidQ = 1'b0;         // program answer stands this cycle
   logic [15:0]    wrCnt    = 16'h0000;     // writes seen, for spurious-write checks

   // ==========================================================
   // one-cycle read answers, writes at the edge
   always @(posedge core_clk) begin
      rdValidQ <= dmRe;
      pwValidQ <= pmRe;
      if (dmRe) begin
         rdQ <= dmemArr[dmAddr];
      end
      if (dmWe) begin
         dmemArr[dmAddr] <= dmWdata;
         wrCnt           <= wrCnt + 16'h0001;
      end
      // word contents depend on page and offset so both show up in the bytes
      if (pmRe) begin
         pwQ <= {pmAddr[7:0] ^ 8'h3c, pmAddr[15:8] + pmAddr[7:0]};
      end
   end

   // outside the answer cycle the lines show the inverse, so stale use is caught
   assign dmRdata = rdValidQ ? rdQ : ~rdQ;
   assign pmRdata = pwValidQ ? pwQ : ~pwQ;
endmodule

// *** tb_top.sv ***
// tb_top: self-checking bench of the execute unit, table of cases then awkward cases
// assumes the unit, its package and the memory model are compiled first
`timescale 1ns/1ps
`define CMP(got, exp) begin checked++; if ((got) !== (exp)) begin errorCnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
   import iexu_pkg::*;
;
   typedef struct packed {
      iexu_op_t  op;                           // operation
      logic [2:0] bs;                          // bit index
      logic [7:0] m, w, f, ew, em, ef;         // memory, work, flags in; work(table: high byte), memory, flags out
      logic       sk;                          // skip expected
      logic [1:0] lat;                         // cycles from take to done
   } iexu_row_t;

   logic core_clk = 1'b0, resetn = 1'b0, opValid = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic opReady, opDone, instSkip, dmRe, dmWe, pmRe;
   iexu_req_t opReq = '0;                      // instruction offered
   logic [DAW-1:0] dmAddr;                     // data address
   logic [DW-1:0]  dmWdata, dmRdata, regRdata; // data lines
   logic [PAW-1:0] pmAddr;                     // program address
   logic [PWW-1:0] pmRdata;                    // program word
   logic [2:0]     regAddr = 3'h0;             // register port address
   logic [DW-1:0]  regWdata = 8'h00;           // register port data
   int errorCnt = 0, checked = 0;              // mismatches and comparisons

   // ==========================================================
   // cases: op bs m w f ew em ef sk lat
   iexu_row_t rows [33] = '{
      '{OP_SWAP_W,3'h0,8'ha5,8'h00,8'h00,8'h5a,8'ha5,8'h00,1'h0,2'h2},
      '{OP_SKIP_Z,3'h0,8'h00,8'h33,8'h1f,8'h33,8'h00,8'h1f,1'h1,2'h3},
      '{OP_SKIP_Z,3'h0,8'h01,8'h33,8'h00,8'h33,8'h01,8'h00,1'h0,2'h2},
      '{OP_SKIP_ZLD,3'h0,8'h00,8'h77,8'h00,8'h00,8'h00,8'h00,1'h1,2'h3},
      '{OP_SKIP_ZLD,3'h0,8'h80,8'h00,8'h04,8'h80,8'h80,8'h04,1'h0,2'h2},
      '{OP_SKIP_BIT,3'h7,8'h7f,8'h00,8'h00,8'h00,8'h7f,8'h00,1'h1,2'h3},
      '{OP_SKIP_BIT,3'h0,8'h01,8'h00,8'h00,8'h00,8'h01,8'h00,1'h0,2'h2},
      '{OP_TRD_PG,3'h0,8'haa,8'hff,8'h1f,8'hc3,8'h11,8'h1f,1'h0,2'h3},
      '{OP_TRD_LAST,3'h0,8'haa,8'h40,8'h1f,8'h7c,8'h3f,8'h1f,1'h0,2'h3},
      '{OP_ITRD_PG,3'h0,8'haa,8'hff,8'h00,8'h3c,8'h12,8'h00,1'h0,2'h3},
      '{OP_ITRD_LST,3'h0,8'haa,8'h7f,8'h00,8'hbc,8'h7f,8'h00,1'h0,2'h3},
      '{OP_XOR_W,3'h0,8'h0f,8'h0f,8'h00,8'h00,8'h0f,8'h04,1'h0,2'h2},
      '{OP_XOR_MEM,3'h0,8'hf0,8'h0f,8'h04,8'h0f,8'hff,8'h00,1'h0,2'h3},
      '{OP_XOR_IMM,3'h0,8'h00,8'h0f,8'h1f,8'hf0,8'h00,8'h1b,1'h0,2'h2},
      '{OP_XADC,3'h0,8'h7f,8'h00,8'h01,8'h80,8'h7f,8'h0a,1'h0,2'h2},
      '{OP_XADC_M,3'h0,8'hff,8'h01,8'h01,8'h01,8'h01,8'h03,1'h0,2'h3},
      '{OP_XADD,3'h0,8'h80,8'h80,8'h01,8'h00,8'h80,8'h1d,1'h0,2'h2},
      '{OP_XADD_M,3'h0,8'h08,8'h08,8'h00,8'h08,8'h10,8'h02,1'h0,2'h3},
      '{OP_XAND,3'h0,8'hf0,8'h0f,8'h00,8'h00,8'hf0,8'h04,1'h0,2'h2},
      '{OP_XAND_M,3'h0,8'h3c,8'hf5,8'h1f,8'hf5,8'h34,8'h1b,1'h0,2'h3},
      '{OP_XCLR,3'h0,8'ha5,8'h11,8'h1f,8'h11,8'h00,8'h1f,1'h0,2'h3},
      '{OP_XCLR_BIT,3'h5,8'hff,8'h11,8'h00,8'h11,8'hdf,8'h00,1'h0,2'h3},
      '{OP_XCPL,3'h0,8'hff,8'h11,8'h00,8'h11,8'h00,8'h04,1'h0,2'h3},
      '{OP_XCPL_W,3'h0,8'h5a,8'h00,8'h04,8'ha5,8'h5a,8'h00,1'h0,2'h2},
      '{OP_XDAA,3'h0,8'h33,8'h15,8'h02,8'h15,8'h1b,8'h02,1'h0,2'h3},
      '{OP_XDAA,3'h0,8'h33,8'ha0,8'h00,8'ha0,8'h00,8'h01,1'h0,2'h3},
      '{OP_XDAA,3'h0,8'h33,8'h99,8'h03,8'h99,8'hff,8'h03,1'h0,2'h3},
      '{OP_XDEC,3'h0,8'h00,8'h11,8'h04,8'h11,8'hff,8'h00,1'h0,2'h3},
      '{OP_XDEC_W,3'h0,8'h01,8'h55,8'h00,8'h00,8'h01,8'h04,1'h0,2'h2},
      '{OP_XINC,3'h0,8'hff,8'h11,8'h00,8'h11,8'h00,8'h04,1'h0,2'h3},
      '{OP_XINC_W,3'h0,8'h7f,8'h00,8'h04,8'h80,8'h7f,8'h00,1'h0,2'h2},
      '{OP_XMOV_W,3'h0,8'h00,8'hff,8'h00,8'h00,8'h00,8'h00,1'h0,2'h2},
      '{OP_XMOV_M,3'h0,8'h10,8'h3c,8'h1f,8'h3c,8'h3c,8'h1f,1'h0,2'h3}};

   // ==========================================================
   // clock, design and partner
   always #12.5 core_clk = ~core_clk;

   iexu_core dut (.core_clk(core_clk), .resetn(resetn), .opValid(opValid), .opReq(opReq), .opReady(opReady),
      .opDone(opDone), .instSkip(instSkip), .dmAddr(dmAddr), .dmRe(dmRe), .dmWe(dmWe), .dmWdata(dmWdata),
      .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
   iexu_mem_model mem_i (.core_clk(core_clk), .dmAddr(dmAddr), .dmRe(dmRe), .dmWe(dmWe), .dmWdata(dmWdata),
      .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata));

   // ==========================================================
   // bus tasks, each entered and left just after a rising edge
   task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic regRead(input logic [2:0] a, output logic [7:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge core_clk);
   endtask

   // offers one op, counts cycles to done, keeps the skip marker
   task automatic runOp(input iexu_op_t op, input logic [11:0] a, input logic [2:0] bs, input logic [7:0] im,
                        output logic [3:0] n, output logic sk);
      opReq <= '{op, a, bs, im};
      opValid <= 1'b1;
      @(posedge core_clk);
      opValid <= 1'b0;
      n = 4'h1;
      #1;
      while (opDone !== 1'b1 && n < 4'h8) begin
         @(posedge core_clk);
         #1 n++;
      end
      sk = instSkip;
      @(posedge core_clk);
   endtask

   task automatic finalReport();
      $display("mismatches %0d comparisons %0d", errorCnt, checked);
      if (errorCnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // watchdog: the whole sequence needs about 515 cycles
   initial begin
      repeat (6000) @(posedge core_clk);
      errorCnt++;
      finalReport();
   end

   // ==========================================================
   // main sequence
   initial begin
      iexu_row_t r;
      logic [11:0] ea;
      logic [7:0] d;
      logic [3:0] n;
      logic sk, tbl;
      logic [15:0] w0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      #1 `CMP({opReady, opDone, dmRe, dmWe, pmRe}, 5'h10)
      @(posedge core_clk);
      regWrite(3'h7, 8'hff);                        // unmapped write is dropped
      for (int a = 0; a < 8; a++) begin
         regRead(3'(a), d);
         `CMP(d, RST_BYTE)
      end
      regWrite(REG_SECT, 8'h03);                    // basic ops land in section 3
      regWrite(REG_PTRHI, 8'h12);
      foreach (rows[i]) begin
         r = rows[i];
         tbl = r.op inside {OP_TRD_PG, OP_TRD_LAST, OP_ITRD_PG, OP_ITRD_LST};
         ea = (r.op >= OP_XADC) ? 12'hf3c : 12'h341;
         mem_i.dmemArr[ea] = r.m;
         regWrite(REG_WORK, r.w);
         regWrite(REG_FLAGS, r.f);
         regWrite(REG_PTRLO, r.w);
         w0 = mem_i.wrCnt;
         runOp(r.op, (r.op >= OP_XADC) ? 12'hf3c : 12'h041, r.bs, ~r.m, n, sk);
         `CMP(n, {2'h0, r.lat})
         `CMP(sk, r.sk)
         regRead(REG_WORK, d);
         `CMP(d, tbl ? r.w : r.ew)
         `CMP(mem_i.dmemArr[ea], r.em)
         `CMP(mem_i.wrCnt - w0, 16'(r.lat == 2'h3 && !r.sk))
         regRead(REG_FLAGS, d);
         `CMP(d, r.ef)
         if (tbl) begin
            regRead(REG_TBLHI, d);
            `CMP(d, r.ew)
            regRead(REG_PTRLO, d);
            `CMP(d, r.w + {7'h00, r.op inside {OP_ITRD_PG, OP_ITRD_LST}})
         end
      end
      // back to back increments on one byte, the second to the working register
      mem_i.dmemArr[12'hf3c] = 8'hfe;
      runOp(OP_XINC, 12'hf3c, 3'h0, 8'h00, n, sk);
      runOp(OP_XINC_W, 12'hf3c, 3'h0, 8'h00, n, sk);
      regRead(REG_WORK, d);
      `CMP(d, 8'h00)
      `CMP(mem_i.dmemArr[12'hf3c], 8'hff)
      regRead(REG_FLAGS, d);
      `CMP(d[F_ZERO], 1'b1)
      // reset in mid-instruction leaves no write and an idle unit
      regWrite(REG_WORK, 8'h3c);
      mem_i.dmemArr[12'hf3c] = 8'h10;
      opReq <= '{OP_XMOV_M, 12'hf3c, 3'h0, 8'h00};
      opValid <= 1'b1;
      @(posedge core_clk);
      opValid <= 1'b0;
      @(posedge core_clk);
      resetn <= 1'b0;
      @(posedge core_clk);
      #1 `CMP({opReady, dmWe}, 2'h2)
      @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      `CMP(mem_i.dmemArr[12'hf3c], 8'h10)
      regRead(REG_WORK, d);
      `CMP(d, RST_BYTE)
      finalReport();
   end
endmodule
